// ---- common/ssr_regs.svh ----
// Bit positions, defined-bit masks and preset values of the status groups.
// Assumes inclusion by the design and checker files by bare name.
`ifndef SSR_REGS_SVH
`define SSR_REGS_SVH

// ----------------------------------------------------------------------------
// Operation group layout
// ----------------------------------------------------------------------------
`define SSR_OPER_CC_BIT 10
`define SSR_OPER_CV_BIT 8
`define SSR_OPER_WTG_BIT 5
`define SSR_OPER_DEFINED 16'h0520

// ----------------------------------------------------------------------------
// Questionable group layout
// ----------------------------------------------------------------------------
`define SSR_QUES_UNR_BIT 10
`define SSR_QUES_INH_BIT 9
`define SSR_QUES_OT_BIT 4
`define SSR_QUES_PF_BIT 2
`define SSR_QUES_OC_BIT 1
`define SSR_QUES_OV_BIT 0
`define SSR_QUES_DEFINED 16'h0617

// ----------------------------------------------------------------------------
// Standard event layout
// ----------------------------------------------------------------------------
`define SSR_STD_PON_BIT 7
`define SSR_STD_DEFINED 8'hBD

// ----------------------------------------------------------------------------
// Summary positions in the status byte
// ----------------------------------------------------------------------------
`define SSR_SB_OPER_BIT 7
`define SSR_SB_ESB_BIT 5
`define SSR_SB_QUES_BIT 3

// ----------------------------------------------------------------------------
// Preset and reset values
// ----------------------------------------------------------------------------
`define SSR_PRESET_RISE 16'h7FFF
`define SSR_PRESET_FALL 16'h0000
`define SSR_PRESET_MASK 16'h0000
`define SSR_RESET_STD_MASK 8'h00

`endif

// ---- common/ssr_pkg.sv ----
// Types shared by the status reporting block: commands, carriers, state.
// Assumes nothing beyond a SystemVerilog compiler.
package ssr_pkg;

    // Remote commands and queries
    typedef enum logic [4:0] {
        SSR_OPER_EVENT_RD, SSR_OPER_COND_RD,
        SSR_OPER_MASK_WR, SSR_OPER_MASK_RD,
        SSR_OPER_FALL_WR, SSR_OPER_FALL_RD,
        SSR_OPER_RISE_WR, SSR_OPER_RISE_RD,
        SSR_QUES_EVENT_RD, SSR_QUES_COND_RD,
        SSR_QUES_MASK_WR, SSR_QUES_MASK_RD,
        SSR_QUES_FALL_WR, SSR_QUES_FALL_RD,
        SSR_QUES_RISE_WR, SSR_QUES_RISE_RD,
        SSR_STD_MASK_WR, SSR_STD_MASK_RD, SSR_STD_EVENT_RD,
        SSR_PRESET, SSR_CLEAR_STATUS
    } ssr_cmd_code_type;

    // Command request
    typedef struct packed {
        logic valid;
        ssr_cmd_code_type code;
        logic [15:0] data;
        logic after_term;
    } ssr_cmd_type;

    // Command answer
    typedef struct packed {
        logic valid;
        logic [15:0] data;
    } ssr_rsp_type;

    // Operating status inputs
    typedef struct packed {
        logic constant_current_flag;
        logic constant_voltage_flag;
        logic trigger_wait_flag;
    } ssr_oper_flags_type;

    // Questionable status inputs
    typedef struct packed {
        logic unregulated_flag;
        logic external_inhibit_flag;
        logic overtemperature_flag;
        logic mains_fail_flag;
        logic overcurrent_flag;
        logic overvoltage_flag;
    } ssr_ques_flags_type;

    // Clear pulses for logic outside the block
    typedef struct packed {
        logic status_byte;
        logic error_queue;
        logic output_queue;
    } ssr_clear_type;

    // State of one 16-bit group
    typedef struct packed {
        logic [15:0] meta;
        logic [15:0] cond;
        logic [15:0] prev;
        logic [15:0] event_bits;
    } ssr_group_state_type;

    // State of the top level
    typedef struct packed {
        logic [15:0] oper_mask;
        logic [15:0] oper_rise;
        logic [15:0] oper_fall;
        logic [15:0] ques_mask;
        logic [15:0] ques_rise;
        logic [15:0] ques_fall;
        logic [7:0] std_mask;
        logic pon_pending;
        ssr_rsp_type rsp;
        logic [7:0] summary;
        ssr_clear_type clr;
    } ssr_top_state_type;

endpackage

// ---- verilog/ssr_status_group.sv ----
// One 16-bit status group: synchronised condition, transition filters and
// the latched event register. Assumes raw inputs arrive from pins.
`timescale 1ns/1ps
`default_nettype none

module ssr_status_group
    import ssr_pkg::*;
#(
    parameter logic [15:0] DEFINED = 16'hFFFF
) (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rst_i,
    // Status inputs and filter settings
    input wire logic [15:0] raw_i,
    input wire logic [15:0] rise_i,
    input wire logic [15:0] fall_i,
    input wire logic clear_i,
    // Register views
    output logic [15:0] cond_o,
    output logic [15:0] event_o
);

    ssr_group_state_type st_r;
    ssr_group_state_type st_nxt;

    // Synchroniser, edge filter and event latch
    always_comb begin
        st_nxt = st_r;
        st_nxt.meta = raw_i & DEFINED;
        st_nxt.cond = st_r.meta;
        st_nxt.prev = st_r.cond;
        st_nxt.event_bits = (st_r.event_bits & ~{16{clear_i}})
            | (st_r.cond & ~st_r.prev & rise_i)
            | (~st_r.cond & st_r.prev & fall_i);
    end

    // State register
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign cond_o = st_r.cond;
    assign event_o = st_r.event_bits;

endmodule

`default_nettype wire

// ---- verilog/ssr_std_event.sv ----
// Standard event register: latches event pulses, cleared as a whole.
// Assumes set pulses come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
`include "ssr_regs.svh"

module ssr_std_event
    import ssr_pkg::*;
(
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rst_i,
    // Event pulses and clear
    input wire logic [7:0] set_i,
    input wire logic clear_i,
    // Register view
    output logic [7:0] event_o
);

    logic [7:0] event_r;
    logic [7:0] event_nxt;

    // Set wins over a clearing read
    always_comb begin
        event_nxt = (event_r & ~{8{clear_i}}) | (set_i & `SSR_STD_DEFINED);
    end

    // State register
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            event_r <= 8'h00;
        end else begin
            event_r <= event_nxt;
        end
    end

    assign event_o = event_r;

endmodule

`default_nettype wire

// ---- verilog/ssr_status_top.sv ----
// Status reporting register system: operation, questionable and standard
// event groups reached through remote commands and queries.
// Assumes commands come from a same-clock parser; status flags from pins.
//
// Operation
// - Preset sets all defined rising filter bits, clears falling filters and the operation and questionable masks.
// - Operation event register latches filtered events; a read returns then clears.
// - Operation bits: constant current 10, constant voltage 8, trigger wait 5.
// - Operation condition register shows the live operating flags.
// - Operation summary is OR of enabled operation events, status byte bit 7.
// - A falling condition bit sets its event when its falling filter is one.
// - A rising condition bit sets its event when its rising filter is one.
// - Questionable event register latches filtered events; reading clears it.
// - Questionable bits: 10,9,4,2,1,0 for unregulated through overvoltage.
// - Questionable condition register shows the live questionable flags.
// - Questionable summary is OR of enabled questionable events, bit 3.
// - Clear status zeroes the standard, operation and questionable event registers.
// - Clear status also clears the status byte and empties the error queue.
// - After a terminator, clear status also empties output queue and MAV.
// - Event summary is OR of enabled standard events; mask reads back as written in its defined bits.
// - Standard bits: PON 7, CME 5, EXE 4, DDE 3, QUE 2, OPC 0.
// - Reading the standard event register returns it then clears it.
`timescale 1ns/1ps
`default_nettype none
`include "ssr_regs.svh"

module ssr_status_top
    import ssr_pkg::*;
(
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rst_i,
    // Command port
    input wire ssr_cmd_type cmd_i,
    output ssr_rsp_type rsp_o,
    // Status flag pins
    input wire ssr_oper_flags_type oper_flags_i,
    input wire ssr_ques_flags_type ques_flags_i,
    // Standard event pulses, same clock
    input wire logic [7:0] std_event_set_i,
    // Summary bits for the status byte
    output logic [7:0] summary_o,
    // Clear pulses for status byte, error queue and output queue
    output ssr_clear_type clear_o
);

    // ------------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------------
    ssr_top_state_type st_r;
    ssr_top_state_type st_nxt;
    logic [15:0] oper_raw;
    logic [15:0] ques_raw;
    logic [15:0] oper_cond;
    logic [15:0] oper_event;
    logic [15:0] ques_cond;
    logic [15:0] ques_event;
    logic [7:0] std_event;
    logic [7:0] std_set;
    logic oper_clear;
    logic ques_clear;
    logic std_clear;

    // ------------------------------------------------------------------------
    // Flag placement
    // ------------------------------------------------------------------------

    // Operation flags onto their bit positions
    always_comb begin
        oper_raw = 16'h0000;
        oper_raw[`SSR_OPER_CC_BIT] = oper_flags_i.constant_current_flag;
        oper_raw[`SSR_OPER_CV_BIT] = oper_flags_i.constant_voltage_flag;
        oper_raw[`SSR_OPER_WTG_BIT] = oper_flags_i.trigger_wait_flag;
    end

    // Questionable flags onto their bit positions
    always_comb begin
        ques_raw = 16'h0000;
        ques_raw[`SSR_QUES_UNR_BIT] = ques_flags_i.unregulated_flag;
        ques_raw[`SSR_QUES_INH_BIT] = ques_flags_i.external_inhibit_flag;
        ques_raw[`SSR_QUES_OT_BIT] = ques_flags_i.overtemperature_flag;
        ques_raw[`SSR_QUES_PF_BIT] = ques_flags_i.mains_fail_flag;
        ques_raw[`SSR_QUES_OC_BIT] = ques_flags_i.overcurrent_flag;
        ques_raw[`SSR_QUES_OV_BIT] = ques_flags_i.overvoltage_flag;
    end

    // ------------------------------------------------------------------------
    // Status groups
    // ------------------------------------------------------------------------

    // Operation group
    ssr_status_group #(
        .DEFINED(`SSR_OPER_DEFINED)
    ) u_oper (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .raw_i(oper_raw),
        .rise_i(st_r.oper_rise),
        .fall_i(st_r.oper_fall),
        .clear_i(oper_clear),
        .cond_o(oper_cond),
        .event_o(oper_event)
    );

    // Questionable group
    ssr_status_group #(
        .DEFINED(`SSR_QUES_DEFINED)
    ) u_ques (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .raw_i(ques_raw),
        .rise_i(st_r.ques_rise),
        .fall_i(st_r.ques_fall),
        .clear_i(ques_clear),
        .cond_o(ques_cond),
        .event_o(ques_event)
    );

    // Power-on event joins the incoming pulses once after reset
    always_comb begin
        std_set = std_event_set_i;
        std_set[`SSR_STD_PON_BIT] = std_event_set_i[`SSR_STD_PON_BIT] | st_r.pon_pending;
    end

    // Standard event group
    ssr_std_event u_std (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .set_i(std_set),
        .clear_i(std_clear),
        .event_o(std_event)
    );

    // ------------------------------------------------------------------------
    // Clearing reads and clear status
    // ------------------------------------------------------------------------

    // Event registers clear on their own query or on clear status
    always_comb begin
        oper_clear = 1'b0;
        ques_clear = 1'b0;
        std_clear = 1'b0;
        if (cmd_i.valid) begin
            case (cmd_i.code)
                SSR_OPER_EVENT_RD: oper_clear = 1'b1;
                SSR_QUES_EVENT_RD: ques_clear = 1'b1;
                SSR_STD_EVENT_RD: std_clear = 1'b1;
                SSR_CLEAR_STATUS: begin
                    oper_clear = 1'b1;
                    ques_clear = 1'b1;
                    std_clear = 1'b1;
                end
                default: begin
                    oper_clear = 1'b0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // Command decode and next state
    // ------------------------------------------------------------------------

    // Writes, queries, preset, clear status and summary bits
    always_comb begin
        st_nxt = st_r;
        st_nxt.pon_pending = 1'b0;
        st_nxt.rsp.valid = cmd_i.valid;
        st_nxt.rsp.data = 16'h0000;
        st_nxt.clr = '0;
        st_nxt.summary = 8'h00;
        st_nxt.summary[`SSR_SB_OPER_BIT] = |(oper_event & st_r.oper_mask);
        st_nxt.summary[`SSR_SB_QUES_BIT] = |(ques_event & st_r.ques_mask);
        st_nxt.summary[`SSR_SB_ESB_BIT] = |(std_event & st_r.std_mask);
        if (cmd_i.valid) begin
            case (cmd_i.code)
                // Operation group
                SSR_OPER_EVENT_RD: st_nxt.rsp.data = oper_event;
                SSR_OPER_COND_RD: st_nxt.rsp.data = oper_cond;
                SSR_OPER_MASK_WR: st_nxt.oper_mask = cmd_i.data & `SSR_OPER_DEFINED;
                SSR_OPER_MASK_RD: st_nxt.rsp.data = st_r.oper_mask;
                SSR_OPER_FALL_WR: st_nxt.oper_fall = cmd_i.data & `SSR_OPER_DEFINED;
                SSR_OPER_FALL_RD: st_nxt.rsp.data = st_r.oper_fall;
                SSR_OPER_RISE_WR: st_nxt.oper_rise = cmd_i.data & `SSR_OPER_DEFINED;
                SSR_OPER_RISE_RD: st_nxt.rsp.data = st_r.oper_rise;
                // Questionable group
                SSR_QUES_EVENT_RD: st_nxt.rsp.data = ques_event;
                SSR_QUES_COND_RD: st_nxt.rsp.data = ques_cond;
                SSR_QUES_MASK_WR: st_nxt.ques_mask = cmd_i.data & `SSR_QUES_DEFINED;
                SSR_QUES_MASK_RD: st_nxt.rsp.data = st_r.ques_mask;
                SSR_QUES_FALL_WR: st_nxt.ques_fall = cmd_i.data & `SSR_QUES_DEFINED;
                SSR_QUES_FALL_RD: st_nxt.rsp.data = st_r.ques_fall;
                SSR_QUES_RISE_WR: st_nxt.ques_rise = cmd_i.data & `SSR_QUES_DEFINED;
                SSR_QUES_RISE_RD: st_nxt.rsp.data = st_r.ques_rise;
                // Standard event group
                SSR_STD_MASK_WR: begin
                    st_nxt.std_mask = cmd_i.data[7:0] & `SSR_STD_DEFINED;
                end
                SSR_STD_MASK_RD: st_nxt.rsp.data = {8'h00, st_r.std_mask};
                SSR_STD_EVENT_RD: st_nxt.rsp.data = {8'h00, std_event};
                // Preset of filters and the operation and questionable masks
                SSR_PRESET: begin
                    st_nxt.oper_rise = `SSR_PRESET_RISE & `SSR_OPER_DEFINED;
                    st_nxt.ques_rise = `SSR_PRESET_RISE & `SSR_QUES_DEFINED;
                    st_nxt.oper_fall = `SSR_PRESET_FALL;
                    st_nxt.ques_fall = `SSR_PRESET_FALL;
                    st_nxt.oper_mask = `SSR_PRESET_MASK;
                    st_nxt.ques_mask = `SSR_PRESET_MASK;
                end
                // Clear status
                SSR_CLEAR_STATUS: begin
                    st_nxt.clr.status_byte = 1'b1;
                    st_nxt.clr.error_queue = 1'b1;
                    st_nxt.clr.output_queue = cmd_i.after_term;
                end
                default: begin
                    st_nxt.rsp.data = 16'h0000;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------------

    // Reset leaves the preset filter values in place and flags power-on
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            st_r.oper_mask <= `SSR_PRESET_MASK;
            st_r.oper_rise <= `SSR_PRESET_RISE & `SSR_OPER_DEFINED;
            st_r.oper_fall <= `SSR_PRESET_FALL;
            st_r.ques_mask <= `SSR_PRESET_MASK;
            st_r.ques_rise <= `SSR_PRESET_RISE & `SSR_QUES_DEFINED;
            st_r.ques_fall <= `SSR_PRESET_FALL;
            st_r.std_mask <= `SSR_RESET_STD_MASK;
            st_r.pon_pending <= 1'b1;
            st_r.rsp <= '0;
            st_r.summary <= 8'h00;
            st_r.clr <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ------------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------------

    // All straight from the state register
    assign rsp_o = st_r.rsp;
    assign summary_o = st_r.summary;
    assign clear_o = st_r.clr;

endmodule

`default_nettype wire

// ---- verif/ssr_status_asserts.sv ----
// Port checker for the status reporting top level.
// Assumes a bind onto ssr_status_top; one clock domain.
`timescale 1ns/1ps
`default_nettype none

module ssr_status_asserts
    import ssr_pkg::*;
(
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rst_i,
    // Watched ports
    input wire ssr_cmd_type cmd_i,
    input wire ssr_rsp_type rsp_o,
    input wire ssr_oper_flags_type oper_flags_i,
    input wire ssr_ques_flags_type ques_flags_i,
    input wire logic [7:0] std_event_set_i,
    input wire logic [7:0] summary_o,
    input wire ssr_clear_type clear_o
);
    `include "ssr_regs.svh"

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);

    logic [7:0] std_mask_r;
    logic [2:0] quiet_r;

    // ------------------------------------------------------------
    // Helper logic
    // ------------------------------------------------------------
    // Flag pins packed into register positions
    function automatic logic [15:0] oper_word(input ssr_oper_flags_type f);
        oper_word = {5'h00, f.constant_current_flag, 1'b0, f.constant_voltage_flag,
            2'h0, f.trigger_wait_flag, 5'h00};
    endfunction
    function automatic logic [15:0] ques_word(input ssr_ques_flags_type f);
        ques_word = {5'h00, f.unregulated_flag, f.external_inhibit_flag, 4'h0,
            f.overtemperature_flag, 1'b0, f.mains_fail_flag, f.overcurrent_flag,
            f.overvoltage_flag};
    endfunction

    // Shadow of the standard mask; count of quiet input cycles
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            std_mask_r <= 8'h00;
            quiet_r <= 3'h0;
        end else begin
            if (cmd_i.valid && cmd_i.code == SSR_STD_MASK_WR) begin
                std_mask_r <= cmd_i.data[7:0] & `SSR_STD_DEFINED;
            end
            if (std_event_set_i == 8'h00 && $stable(oper_flags_i) && $stable(ques_flags_i)) begin
                quiet_r <= (quiet_r == 3'h7) ? quiet_r : quiet_r + 3'h1;
            end else begin
                quiet_r <= 3'h0;
            end
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    sequence s_cls;
        cmd_i.valid && cmd_i.code == SSR_CLEAR_STATUS;
    endsequence
    sequence s_preset_idle;
        (cmd_i.valid && cmd_i.code == SSR_PRESET) ##1 !cmd_i.valid;
    endsequence

    a_rsp_one_cycle: assert property (rsp_o.valid == $past(cmd_i.valid))
        else $error("response valid not one cycle after command");
    a_cls_pulses: assert property (s_cls |=> clear_o.status_byte
        && clear_o.error_queue && (clear_o.output_queue == $past(cmd_i.after_term)))
        else $error("clear pulses wrong after clear status");
    a_no_stray_clear: assert property (!(cmd_i.valid && cmd_i.code == SSR_CLEAR_STATUS)
        |=> clear_o == 3'h0)
        else $error("clear pulse without clear status");
    a_summary_unused: assert property ((summary_o & 8'h57) == 8'h00)
        else $error("summary bit outside used positions");
    a_oper_undef_zero: assert property (cmd_i.valid && cmd_i.code inside {
        SSR_OPER_EVENT_RD, SSR_OPER_COND_RD, SSR_OPER_MASK_RD, SSR_OPER_FALL_RD, SSR_OPER_RISE_RD}
        |=> (rsp_o.data & ~`SSR_OPER_DEFINED) == 16'h0000)
        else $error("operation read shows undefined bits");
    a_ques_undef_zero: assert property (cmd_i.valid && cmd_i.code inside {
        SSR_QUES_EVENT_RD, SSR_QUES_COND_RD, SSR_QUES_MASK_RD, SSR_QUES_FALL_RD, SSR_QUES_RISE_RD}
        |=> (rsp_o.data & ~`SSR_QUES_DEFINED) == 16'h0000)
        else $error("questionable read shows undefined bits");
    a_std_undef_zero: assert property (cmd_i.valid
        && cmd_i.code inside {SSR_STD_MASK_RD, SSR_STD_EVENT_RD}
        |=> (rsp_o.data & ~{8'h00, `SSR_STD_DEFINED}) == 16'h0000)
        else $error("standard read shows undefined bits");
    a_oper_cond_live: assert property (($stable(oper_flags_i)[*4] ##0 (cmd_i.valid
        && cmd_i.code == SSR_OPER_COND_RD)) |=> rsp_o.data == oper_word($past(oper_flags_i)))
        else $error("operation condition not live");
    a_ques_cond_live: assert property (($stable(ques_flags_i)[*4] ##0 (cmd_i.valid
        && cmd_i.code == SSR_QUES_COND_RD)) |=> rsp_o.data == ques_word($past(ques_flags_i)))
        else $error("questionable condition not live");
    a_preset_summary: assert property (s_preset_idle |=> !summary_o[7]
        && !summary_o[3])
        else $error("summary set after preset");
    a_cls_summary: assert property ((s_cls ##0 (quiet_r >= 3'h3
        && std_event_set_i == 8'h00)) ##1 (!cmd_i.valid && std_event_set_i == 8'h00
        && $stable(oper_flags_i) && $stable(ques_flags_i)) |=> summary_o == 8'h00)
        else $error("summary set after clear status");
    a_std_mask_back: assert property (cmd_i.valid && cmd_i.code == SSR_STD_MASK_RD
        |=> rsp_o.data == {8'h00, $past(std_mask_r)})
        else $error("standard mask readback differs");
endmodule

bind ssr_status_top ssr_status_asserts u_asserts (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .cmd_i(cmd_i), .rsp_o(rsp_o),
    .oper_flags_i(oper_flags_i), .ques_flags_i(ques_flags_i),
    .std_event_set_i(std_event_set_i), .summary_o(summary_o), .clear_o(clear_o)
);

`default_nettype wire

// ---- verif/tb_top.sv ----
// Self-checking bench for the status reporting top level.
// Assumes the checker is bound in; inputs change on the falling edge.
`timescale 1ns/1ps
`default_nettype none

module tb_top
    import ssr_pkg::*;
;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    ssr_cmd_type cmd = '0;
    ssr_rsp_type rsp;
    ssr_oper_flags_type oper_flags = '0;
    ssr_ques_flags_type ques_flags = '0;
    logic [7:0] std_set = 8'h00;
    logic [7:0] summary;
    ssr_clear_type clr;
    int mismatches = 0;
    int check_count = 0;
    logic [15:0] got;
    ssr_clear_type got_clr;
    logic [15:0] defs [2] = '{16'h0520, 16'h0617};
    logic [15:0] fall_pick [2] = '{16'h0400, 16'h0001};
    logic [15:0] rise_pick [2] = '{16'h0100, 16'h0004};
    int sbit [2] = '{7, 3};

    // 40 MHz clock
    always #12.5 core_clk = ~core_clk;

    ssr_status_top DUT (
        .core_clk_i(core_clk), .rst_i(rst), .cmd_i(cmd), .rsp_o(rsp),
        .oper_flags_i(oper_flags), .ques_flags_i(ques_flags),
        .std_event_set_i(std_set), .summary_o(summary), .clear_o(clr)
    );

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic give_verdict();
        if (mismatches == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic chk16(input logic [15:0] g, input logic [15:0] e);
        check_count++;
        if (g !== e) begin
            mismatches++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic chk1(input logic g, input logic e);
        chk16({15'h0000, g}, {15'h0000, e});
    endtask
    // One command with an optional event pulse beside it
    task automatic send(input ssr_cmd_code_type c, input logic [15:0] d, input logic t,
        input logic [7:0] p);
        @(negedge core_clk);
        cmd = '{1'b1, c, d, t};
        std_set = p;
        @(negedge core_clk);
        // Answer and clear pulses stand for one cycle only
        got = rsp.data;
        got_clr = clr;
        chk1(rsp.valid, 1'b1);
        cmd.valid = 1'b0;
        std_set = 8'h00;
        @(negedge core_clk);
    endtask
    task automatic rd(input ssr_cmd_code_type c, input logic [15:0] e);
        send(c, 16'h0000, 1'b0, 8'h00);
        chk16(got, e);
    endtask
    task automatic wr(input ssr_cmd_code_type c, input logic [15:0] d);
        send(c, d, 1'b0, 8'h00);
    endtask
    // Group g command k, using the enum's group layout
    function automatic ssr_cmd_code_type gc(input int g, input int k);
        gc = ssr_cmd_code_type'(5'(g * 8 + k));
    endfunction
    // Drive all flags of one group, then let events settle
    task automatic flags(input int g, input logic v);
        @(negedge core_clk);
        if (g == 0) begin
            oper_flags = {3{v}};
        end else begin
            ques_flags = {6{v}};
        end
        repeat (5) @(negedge core_clk);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset_values();
        for (int g = 0; g < 2; g++) begin
            rd(gc(g, 7), defs[g]);
            rd(gc(g, 5), 16'h0000);
            rd(gc(g, 3), 16'h0000);
            rd(gc(g, 0), 16'h0000);
            rd(gc(g, 1), 16'h0000);
        end
        rd(SSR_STD_MASK_RD, 16'h0000);
        rd(SSR_STD_EVENT_RD, 16'h0080);
        rd(SSR_STD_EVENT_RD, 16'h0000);
    endtask
    task automatic t_group_events();
        for (int g = 0; g < 2; g++) begin
            wr(gc(g, 2), 16'hFFFF);
            rd(gc(g, 3), defs[g]);
            flags(g, 1'b1);
            rd(gc(g, 1), defs[g]);
            chk1(summary[sbit[g]], 1'b1);
            rd(gc(g, 0), defs[g]);
            rd(gc(g, 0), 16'h0000);
            chk1(summary[sbit[g]], 1'b0);
            wr(gc(g, 4), fall_pick[g]);
            wr(gc(g, 6), rise_pick[g]);
            flags(g, 1'b0);
            rd(gc(g, 0), fall_pick[g]);
            flags(g, 1'b1);
            rd(gc(g, 0), rise_pick[g]);
            wr(gc(g, 4), 16'h0000);
            wr(gc(g, 6), 16'h0000);
            flags(g, 1'b0);
            rd(gc(g, 0), 16'h0000);
        end
    endtask
    task automatic t_preset();
        wr(SSR_STD_MASK_WR, 16'h00FF);
        wr(SSR_OPER_FALL_WR, 16'hFFFF);
        wr(SSR_QUES_FALL_WR, 16'hFFFF);
        send(SSR_PRESET, 16'h0000, 1'b0, 8'h00);
        for (int g = 0; g < 2; g++) begin
            rd(gc(g, 7), defs[g]);
            rd(gc(g, 5), 16'h0000);
            rd(gc(g, 3), 16'h0000);
        end
        rd(SSR_STD_MASK_RD, 16'h00BD);
    endtask
    // Clearing read lands in the same cycle as new events
    task automatic t_std_events();
        send(SSR_STD_EVENT_RD, 16'h0000, 1'b0, 8'hFF);
        chk16(got, 16'h0000);
        chk1(summary[5], 1'b1);
        rd(SSR_STD_EVENT_RD, 16'h00BD);
        rd(SSR_STD_EVENT_RD, 16'h0000);
        chk1(summary[5], 1'b0);
    endtask
    task automatic t_clear_status();
        wr(SSR_OPER_MASK_WR, 16'hFFFF);
        wr(SSR_QUES_MASK_WR, 16'hFFFF);
        for (int t = 0; t < 2; t++) begin
            send(SSR_STD_MASK_RD, 16'h0000, 1'b0, 8'h20);
            flags(0, 1'b1);
            flags(1, 1'b1);
            chk16({8'h00, summary}, 16'h00A8);
            send(SSR_CLEAR_STATUS, 16'h0000, t == 1, 8'h00);
            chk1(got_clr.status_byte, 1'b1);
            chk1(got_clr.error_queue, 1'b1);
            chk1(got_clr.output_queue, t == 1);
            chk16({8'h00, summary}, 16'h0000);
            rd(SSR_OPER_EVENT_RD, 16'h0000);
            rd(SSR_QUES_EVENT_RD, 16'h0000);
            rd(SSR_STD_EVENT_RD, 16'h0000);
            flags(0, 1'b0);
            flags(1, 1'b0);
        end
    endtask

    // Main sequence
    initial begin
        repeat (12) @(negedge core_clk);
        rst = 1'b0;
        t_reset_values();
        t_group_events();
        t_preset();
        t_std_events();
        t_clear_status();
        give_verdict();
    end

    // Watchdog at 5000 cycles, over ten times the expected run of about three hundred cycles
    initial begin
        #(25 * 5000);
        mismatches++;
        give_verdict();
    end
endmodule

`default_nettype wire
